// ==== bench/alert_source.sv ====
`timescale 1ns/1ps
// Far party on the alert line: holds it low for a commanded span
module alert_source (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Command from the bench
	input wire logic start,
	input wire logic [15:0] low_cycles,
	// Alert line, pulled up when released
	output logic alert_n
);
	logic [15:0] left;
	// Span counter; the pull-up restores high once it runs out
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			left <= 16'h0000;
		else if (start)
			left <= low_cycles;
		else if (left != 16'h0000)
			left <= left - 16'h0001;
	end
	assign alert_n = (left == 16'h0000);
endmodule : alert_source

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	localparam int sc = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic watchdog_expiry = 1'b0;
	logic start = 1'b0;
	logic [15:0] low_cycles = 16'h0000;
	logic [7:0] rdata, v;
	logic watchdog_restart, alert_n, power_switch_off, input_path_off, charge_inhibit;
	logic precharge_exit_level, refill_margin;
	logic [2:0] battery_undervoltage_level;
	logic [5:0] charge_current, battery_target_voltage;
	logic [3:0] discharge_limit, termination_current;
	logic [31:0] outs;
	logic [7:0] sh [1:4];
	int fail_count = 0;
	int n_tests = 0;
	int i, k;
	always #5 clk = ~clk;
	// Settings bundled so one compare covers them all
	assign outs = {5'h00, input_path_off, charge_inhibit, battery_undervoltage_level, charge_current,
		discharge_limit, termination_current, battery_target_voltage, precharge_exit_level, refill_margin};
	charger_config_registers #(.second_cycles(sc)) charger_config_registers_inst (.clk(clk), .rst_n(rst_n),
		.wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
		.watchdog_expiry(watchdog_expiry), .watchdog_restart(watchdog_restart), .alert_n(alert_n),
		.power_switch_off(power_switch_off), .input_path_off(input_path_off), .charge_inhibit(charge_inhibit),
		.battery_undervoltage_level(battery_undervoltage_level), .charge_current(charge_current),
		.discharge_limit(discharge_limit), .termination_current(termination_current),
		.battery_target_voltage(battery_target_voltage), .precharge_exit_level(precharge_exit_level),
		.refill_margin(refill_margin));
	alert_source alert_source_inst (.clk(clk), .rst_n(rst_n), .start(start), .low_cycles(low_cycles),
		.alert_n(alert_n));
	// Expected settings; clamp and floor follow the code limits
	function automatic logic [31:0] exp_out();
		logic [5:0] cc;
		logic [3:0] dl;
		cc = (sh[2][5:0] > 6'h38) ? 6'h38 : sh[2][5:0];
		dl = (sh[3][7:4] == 4'h0) ? 4'h1 : sh[3][7:4];
		return {5'h00, sh[1][4:0], cc, dl, sh[3][3:0], sh[4]};
	endfunction : exp_out
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task give_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	// Strobes drop with an idle cycle after, so no signal is set twice at one instant
	task wr(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		#1;
		wr_en <= 1'b0;
		@(posedge clk);
		#1;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		#1;
		rd_en <= 1'b0;
		d = rdata;
		@(posedge clk);
		#1;
	endtask : rd
	task defaults();
		sh[1] = charger_pkg::RST_POWER_ON_CONFIG;
		sh[2] = charger_pkg::RST_CHARGE_CURRENT_CONTROL & 8'h3f;
		sh[3] = charger_pkg::RST_DISCHARGE_TERMINATION_CURRENT;
		sh[4] = charger_pkg::RST_CHARGE_VOLTAGE_CONTROL;
	endtask : defaults
	task chk_all(input string what);
		for (k = 1; k <= 4; k++)
		begin
			rd(k[7:0], v);
			chk(what, {24'h0, sh[k]}, {24'h0, v});
		end
		chk({what, "_settings"}, exp_out(), outs);
	endtask : chk_all
	// Random bytes, with all-ones (0x3f at register 2) and all-zeros as corner passes
	task scramble(input int pass);
		for (k = 1; k <= 4; k++)
		begin
			v = 8'($urandom());
			if (pass == 0)
				v = 8'hff;
			if (pass == 1)
				v = 8'h00;
			if (k == 2)
				v = v & 8'h3f;
			sh[k] = v;
			wr(k[7:0], v);
		end
	endtask : scramble
	// Alert one cycle short of the hold time must not cut; then held past it
	task cut(input logic [1:0] hs, input logic os);
		int hold, off, t;
		hold = (8 + 4 * hs) * sc;
		off = (os ? 4 : 2) * sc;
		sh[1] = {hs, os, sh[1][4:0]};
		wr(8'h01, sh[1]);
		low_cycles <= 16'(hold - 1);
		start <= 1'b1;
		@(posedge clk);
		#1;
		start <= 1'b0;
		repeat (hold + 4) @(posedge clk);
		#1;
		chk("short_alert", 0, power_switch_off);
		low_cycles <= 16'(hold + off + 20);
		start <= 1'b1;
		@(posedge clk);
		#1;
		start <= 1'b0;
		// Sampled 1 ns after each edge, once the state register has settled
		for (t = 0; power_switch_off !== 1'b1 && t < hold + 10; t++)
		begin
			@(posedge clk);
			#1;
		end
		chk("hold_cycles", hold, t);
		if (power_switch_off !== 1'b1)
			give_verdict();
		for (t = 0; power_switch_off !== 1'b0 && t < off + 10; t++)
		begin
			@(posedge clk);
			#1;
		end
		chk("off_cycles", off, t);
		if (power_switch_off !== 1'b0)
			give_verdict();
		repeat (30) @(posedge clk);
		#1;
		chk("no_second_cut", 0, power_switch_off);
	endtask : cut
	initial
	begin
		void'($urandom(45));
		repeat (8) @(posedge clk);
		#1;
		rst_n <= 1'b1;
		defaults();
		chk_all("reset");
		rd(8'h00, v);
		chk("unmapped_read", 0, v);
		for (i = 0; i < 12; i++)
		begin
			scramble(i);
			chk_all("readback");
		end
		// Write then read on the very next cycle
		for (i = 0; i < 4; i++)
		begin
			v = 8'($urandom());
			addr <= 8'h04;
			wdata <= v;
			wr_en <= 1'b1;
			@(posedge clk);
			#1;
			wr_en <= 1'b0;
			rd_en <= 1'b1;
			@(posedge clk);
			#1;
			rd_en <= 1'b0;
			chk("write_then_read", {24'h0, v}, {24'h0, rdata});
			sh[4] = v;
			@(posedge clk);
			#1;
		end
		chk("restart_idle", 0, watchdog_restart);
		addr <= 8'h02;
		wdata <= {2'b01, sh[2][5:0]};
		wr_en <= 1'b1;
		#2;
		chk("restart_pulse", 1, watchdog_restart);
		@(posedge clk);
		#1;
		wr_en <= 1'b0;
		@(posedge clk);
		#1;
		chk_all("restart_clear");
		wr(8'h02, 8'h80 | sh[2]);
		defaults();
		chk_all("restore");
		scramble(5);
		// Expiry together with a restart write: write lost, pulse held back
		addr <= 8'h02;
		wdata <= 8'h7f;
		wr_en <= 1'b1;
		watchdog_expiry <= 1'b1;
		#2;
		chk("restart_masked", 0, watchdog_restart);
		@(posedge clk);
		#1;
		wr_en <= 1'b0;
		watchdog_expiry <= 1'b0;
		defaults();
		chk_all("watchdog");
		for (i = 0; i < 4; i++)
			cut(i[1:0], i[0]);
		give_verdict();
	end
	// Hang guard
	initial
	begin
		#900000;
		fail_count++;
		give_verdict();
	end
endmodule : tb_top

// ==== rtl/battery_cut_if.sv ====
`timescale 1ns/1ps
interface battery_cut_if;
	logic [1:0] hold_sel;
	logic off_sel;
	logic switch_off;
	modport config_side (output hold_sel, output off_sel, input switch_off);
	modport timer_side (input hold_sel, input off_sel, output switch_off);
endinterface : battery_cut_if

// ==== rtl/battery_cut_timer.sv ====
`timescale 1ns/1ps
module battery_cut_timer #(
	parameter int second_cycles = charger_pkg::SECOND_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Alert line from the far party
	input wire logic alert_n,
	// Settings in, switch state out
	battery_cut_if.timer_side cut
);
	initial
	begin
		if (second_cycles < 2)
			$error("second_cycles must be at least 2");
	end

	function automatic logic [4:0] hold_seconds(input logic [1:0] sel);
		hold_seconds = charger_pkg::HOLD_BASE_S + 5'(charger_pkg::HOLD_STEP_S * 5'(sel));
	endfunction : hold_seconds

	charger_pkg::cut_state_type state;
	charger_pkg::cut_state_type next_state;
	logic [31:0] cycle_count;
	logic [4:0] seconds;
	logic second_tick;
	logic [4:0] seconds_plus;
	logic [4:0] hold_target;
	logic [4:0] off_target;
	logic restart_count;

	// Second prescaler taps and targets
	assign second_tick = (cycle_count == 32'(second_cycles - 1));
	assign seconds_plus = seconds + 5'h01;
	assign hold_target = hold_seconds(cut.hold_sel);
	assign off_target = cut.off_sel ? charger_pkg::OFF_LONG_S : charger_pkg::OFF_SHORT_S;
	assign cut.switch_off = (state == charger_pkg::cut_off);

	// Hold time ends the watch, off time ends the cut
	always_comb
	begin
		next_state = state;
		restart_count = 1'b0;
		unique case (state)
			charger_pkg::cut_watch:
			begin
				if (alert_n)
					restart_count = 1'b1;
				else if (second_tick && seconds_plus == hold_target)
				begin
					next_state = charger_pkg::cut_off;
					restart_count = 1'b1;
				end
			end
			charger_pkg::cut_off:
			begin
				// Alert level is ignored while off
				if (second_tick && seconds_plus == off_target)
				begin
					next_state = charger_pkg::cut_watch;
					restart_count = 1'b1;
				end
			end
		endcase
	end

	// State and counters
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state <= charger_pkg::cut_watch;
			cycle_count <= 32'h0000_0000;
			seconds <= 5'h00;
		end
		else
		begin
			state <= next_state;
			cycle_count <= (restart_count || second_tick) ? 32'h0000_0000 : cycle_count + 32'h0000_0001;
			seconds <= restart_count ? 5'h00 : (second_tick ? seconds_plus : seconds);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_release_clears;
		(state == charger_pkg::cut_watch) && alert_n |=> (seconds == 5'h00) && !cut.switch_off;
	endproperty
	a_release_clears: assert property (p_release_clears) else $error("alert release did not clear hold count");

	property p_hold_expires;
		(state == charger_pkg::cut_watch) && !alert_n && second_tick && (seconds_plus == hold_target)
			|=> cut.switch_off && (seconds == 5'h00);
	endproperty
	a_hold_expires: assert property (p_hold_expires) else $error("switch not cut at hold time");

	property p_off_ends;
		cut.switch_off && second_tick && (seconds_plus == off_target) |=> !cut.switch_off;
	endproperty
	a_off_ends: assert property (p_off_ends) else $error("switch not restored at off time");

	property p_off_early;
		cut.switch_off && (seconds_plus != off_target) && second_tick |=> cut.switch_off;
	endproperty
	a_off_early: assert property (p_off_early) else $error("switch restored early");
endmodule : battery_cut_timer

// ==== rtl/charger_config_registers.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Hold select picks 8/12/16/20 s cut
// - Off select picks 2 s or 4 s
// - Input path bit turns regulator switch off
// - Charge inhibit defaults set, blocks charging
// - Three-bit battery undervoltage level code
// - Restore bit reloads defaults; restart kicks watchdog
// - Six-bit fast-charge current, max code 111000
// - Discharge limit and termination current codes
// - Six-bit battery target voltage code
// - Precharge exit level select bit
// - Refill margin select bit
// - Restore and watchdog expiry reload defaults
// - Long alert low cuts switch, auto-restores
module charger_config_registers #(
	parameter int second_cycles = charger_pkg::SECOND_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Byte register port from the serial engine
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [charger_pkg::ADDR_W-1:0] addr,
	input wire logic [charger_pkg::DATA_W-1:0] wdata,
	output logic [charger_pkg::DATA_W-1:0] rdata,
	// Watchdog link
	input wire logic watchdog_expiry,
	output logic watchdog_restart,
	// Alert line and battery switch
	input wire logic alert_n,
	output logic power_switch_off,
	// Settings to the analog loops
	output logic input_path_off,
	output logic charge_inhibit,
	output logic [2:0] battery_undervoltage_level,
	output logic [5:0] charge_current,
	output logic [3:0] discharge_limit,
	output logic [3:0] termination_current,
	output logic [5:0] battery_target_voltage,
	output logic precharge_exit_level,
	output logic refill_margin
);
	initial
	begin
		if (charger_pkg::ADDR_W != 8 || charger_pkg::DATA_W != 8)
			$error("register port must be byte wide");
	end

	logic [7:0] power_on_config;
	logic [5:0] charge_current_code;
	logic [7:0] discharge_termination_current;
	logic [7:0] charge_voltage_control;
	logic [7:0] next_rdata;

	// Write decode
	wire write_power = wr_en && (addr == charger_pkg::ADDR_POWER_ON_CONFIG);
	wire write_current = wr_en && (addr == charger_pkg::ADDR_CHARGE_CURRENT_CONTROL);
	wire write_discharge = wr_en && (addr == charger_pkg::ADDR_DISCHARGE_TERMINATION_CURRENT);
	wire write_voltage = wr_en && (addr == charger_pkg::ADDR_CHARGE_VOLTAGE_CONTROL);
	wire restore = write_current && wdata[charger_pkg::RESTORE_BIT];
	wire reload = restore || watchdog_expiry;

	// Restart is a pulse; the bit itself is never stored
	assign watchdog_restart = write_current && wdata[charger_pkg::WATCHDOG_RESTART_BIT] && !watchdog_expiry;

	// Registers; any reload beats a plain write in the same cycle
	always_ff @(posedge clk)
	begin
		if (!rst_n || reload)
		begin
			power_on_config <= charger_pkg::RST_POWER_ON_CONFIG;
			charge_current_code <= charger_pkg::RST_CHARGE_CURRENT_CONTROL[charger_pkg::CHARGE_CURRENT_MSB:0];
			discharge_termination_current <= charger_pkg::RST_DISCHARGE_TERMINATION_CURRENT;
			charge_voltage_control <= charger_pkg::RST_CHARGE_VOLTAGE_CONTROL;
		end
		else
		begin
			if (write_power)
				power_on_config <= wdata;
			if (write_current)
				charge_current_code <= wdata[charger_pkg::CHARGE_CURRENT_MSB:0];
			if (write_discharge)
				discharge_termination_current <= wdata;
			if (write_voltage)
				charge_voltage_control <= wdata;
		end
	end

	// Read mux; control bits of the current register read zero
	always_comb
	begin
		next_rdata = 8'h00;
		if (rd_en)
		begin
			if (addr == charger_pkg::ADDR_POWER_ON_CONFIG)
				next_rdata = power_on_config;
			else if (addr == charger_pkg::ADDR_CHARGE_CURRENT_CONTROL)
				next_rdata = {2'b00, charge_current_code};
			else if (addr == charger_pkg::ADDR_DISCHARGE_TERMINATION_CURRENT)
				next_rdata = discharge_termination_current;
			else if (addr == charger_pkg::ADDR_CHARGE_VOLTAGE_CONTROL)
				next_rdata = charge_voltage_control;
		end
	end

	// Read data register, held between reads
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rdata <= 8'h00;
		else if (rd_en)
			rdata <= next_rdata;
	end

	// Field outputs; unsupported codes are clamped so the loops never see them
	assign input_path_off = power_on_config[charger_pkg::INPUT_PATH_OFF_BIT];
	assign charge_inhibit = power_on_config[charger_pkg::CHARGE_INHIBIT_BIT];
	assign battery_undervoltage_level = power_on_config[charger_pkg::UNDERVOLTAGE_MSB:0];
	assign charge_current = (charge_current_code > charger_pkg::CHARGE_CURRENT_MAX_CODE)
		? charger_pkg::CHARGE_CURRENT_MAX_CODE : charge_current_code;
	wire [3:0] discharge_code = discharge_termination_current[charger_pkg::DISCHARGE_LIMIT_MSB:charger_pkg::DISCHARGE_LIMIT_LSB];
	assign discharge_limit = (discharge_code < charger_pkg::DISCHARGE_LIMIT_MIN_CODE)
		? charger_pkg::DISCHARGE_LIMIT_MIN_CODE : discharge_code;
	assign termination_current = discharge_termination_current[charger_pkg::TERMINATION_MSB:0];
	assign battery_target_voltage =
		charge_voltage_control[charger_pkg::TARGET_VOLTAGE_MSB:charger_pkg::TARGET_VOLTAGE_LSB];
	assign precharge_exit_level = charge_voltage_control[charger_pkg::PRECHARGE_EXIT_BIT];
	assign refill_margin = charge_voltage_control[charger_pkg::REFILL_MARGIN_BIT];

	// Battery-cut sequencer
	battery_cut_if cut ();
	assign cut.hold_sel = power_on_config[charger_pkg::HOLD_SEL_MSB:charger_pkg::HOLD_SEL_LSB];
	assign cut.off_sel = power_on_config[charger_pkg::OFF_SEL_BIT];
	assign power_switch_off = cut.switch_off;

	battery_cut_timer #(
		.second_cycles(second_cycles)
	) cut_timer (
		.clk(clk),
		.rst_n(rst_n),
		.alert_n(alert_n),
		.cut(cut.timer_side)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_restore_all;
		wr_en && (addr == charger_pkg::ADDR_CHARGE_CURRENT_CONTROL) && wdata[7]
			|=> (power_on_config == 8'hac) && (charge_current_code == 6'h0f)
			&& (discharge_termination_current == 8'h91) && (charge_voltage_control == 8'ha3);
	endproperty
	a_restore_all: assert property (p_restore_all) else $error("restore did not reload defaults");

	property p_expiry_reload;
		watchdog_expiry |=> charge_inhibit && (battery_undervoltage_level == 3'h4)
			&& (battery_target_voltage == 6'h28) && (termination_current == 4'h1);
	endproperty
	a_expiry_reload: assert property (p_expiry_reload) else $error("watchdog expiry did not reload defaults");

	property p_restart_pulse;
		wr_en && (addr == 8'h02) && wdata[6] && !watchdog_expiry |-> watchdog_restart;
	endproperty
	a_restart_pulse: assert property (p_restart_pulse) else $error("restart write gave no pulse");

	property p_control_bits_zero;
		rd_en && (addr == 8'h02) |=> (rdata[7:6] == 2'b00);
	endproperty
	a_control_bits_zero: assert property (p_control_bits_zero) else $error("control bits did not read zero");

	property p_inhibit_write;
		wr_en && (addr == 8'h01) && !watchdog_expiry |=> (charge_inhibit == $past(wdata[3]))
			&& (input_path_off == $past(wdata[4]));
	endproperty
	a_inhibit_write: assert property (p_inhibit_write) else $error("inhibit or input path bit not written");

	property p_current_clamp;
		charge_current <= 6'h38;
	endproperty
	a_current_clamp: assert property (p_current_clamp) else $error("charge current above supported code");

	property p_discharge_valid;
		discharge_limit != 4'h0;
	endproperty
	a_discharge_valid: assert property (p_discharge_valid) else $error("discharge limit code zero");

	property p_readback;
		wr_en && (addr == 8'h04) && !watchdog_expiry ##1 rd_en && (addr == 8'h04) && !wr_en
			|=> rdata == $past(wdata, 2);
	endproperty
	a_readback: assert property (p_readback) else $error("voltage register readback mismatch");

	// Reset is checked while it is asserted, so it cannot be disabled by itself
	property p_reset_load;
		disable iff (1'b0) !rst_n |=> (power_on_config == 8'hac) && (rdata == 8'h00) && !power_switch_off;
	endproperty
	a_reset_load: assert property (p_reset_load) else $error("reset did not load defaults");

	property p_level_write;
		wr_en && (addr == 8'h01) && !watchdog_expiry |=> (battery_undervoltage_level == $past(wdata[2:0]));
	endproperty
	a_level_write: assert property (p_level_write) else $error("undervoltage level not written");

	property p_select_write;
		wr_en && (addr == 8'h01) && !watchdog_expiry |=> (cut.hold_sel == $past(wdata[7:6]));
	endproperty
	a_select_write: assert property (p_select_write) else $error("hold select not written");

	property p_off_select_write;
		wr_en && (addr == 8'h01) && !watchdog_expiry |=> (cut.off_sel == $past(wdata[5]));
	endproperty
	a_off_select_write: assert property (p_off_select_write) else $error("off select not written");

	property p_termination_write;
		wr_en && (addr == 8'h03) && !watchdog_expiry |=> (termination_current == $past(wdata[3:0]));
	endproperty
	a_termination_write: assert property (p_termination_write) else $error("termination code not written");

	property p_precharge_write;
		wr_en && (addr == 8'h04) && !watchdog_expiry |=> (precharge_exit_level == $past(wdata[1]));
	endproperty
	a_precharge_write: assert property (p_precharge_write) else $error("precharge exit bit not written");

	property p_margin_write;
		wr_en && (addr == 8'h04) && !watchdog_expiry |=> (refill_margin == $past(wdata[0]));
	endproperty
	a_margin_write: assert property (p_margin_write) else $error("refill margin bit not written");
endmodule : charger_config_registers

// ==== rtl/charger_pkg.sv ====
package charger_pkg;
	// Register map
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] ADDR_POWER_ON_CONFIG = 8'h01;
	localparam logic [7:0] ADDR_CHARGE_CURRENT_CONTROL = 8'h02;
	localparam logic [7:0] ADDR_DISCHARGE_TERMINATION_CURRENT = 8'h03;
	localparam logic [7:0] ADDR_CHARGE_VOLTAGE_CONTROL = 8'h04;
	localparam logic [7:0] RST_POWER_ON_CONFIG = 8'hac;
	localparam logic [7:0] RST_CHARGE_CURRENT_CONTROL = 8'h0f;
	localparam logic [7:0] RST_DISCHARGE_TERMINATION_CURRENT = 8'h91;
	localparam logic [7:0] RST_CHARGE_VOLTAGE_CONTROL = 8'ha3;
	// Field positions
	localparam int HOLD_SEL_MSB = 7;
	localparam int HOLD_SEL_LSB = 6;
	localparam int OFF_SEL_BIT = 5;
	localparam int INPUT_PATH_OFF_BIT = 4;
	localparam int CHARGE_INHIBIT_BIT = 3;
	localparam int UNDERVOLTAGE_MSB = 2;
	localparam int RESTORE_BIT = 7;
	localparam int WATCHDOG_RESTART_BIT = 6;
	localparam int CHARGE_CURRENT_MSB = 5;
	localparam int DISCHARGE_LIMIT_MSB = 7;
	localparam int DISCHARGE_LIMIT_LSB = 4;
	localparam int TERMINATION_MSB = 3;
	localparam int TARGET_VOLTAGE_MSB = 7;
	localparam int TARGET_VOLTAGE_LSB = 2;
	localparam int PRECHARGE_EXIT_BIT = 1;
	localparam int REFILL_MARGIN_BIT = 0;
	// Code limits
	localparam logic [5:0] CHARGE_CURRENT_MAX_CODE = 6'h38;
	localparam logic [3:0] DISCHARGE_LIMIT_MIN_CODE = 4'h1;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SECOND_NS = 1000000000;
	localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
	localparam logic [4:0] HOLD_BASE_S = 5'h08;
	localparam logic [4:0] HOLD_STEP_S = 5'h04;
	localparam logic [4:0] OFF_SHORT_S = 5'h02;
	localparam logic [4:0] OFF_LONG_S = 5'h04;
	// Battery-cut sequencer states
	typedef enum logic [0:0] {
		cut_watch = 1'b0,
		cut_off = 1'b1
	} cut_state_type;
endpackage : charger_pkg
